// >>> verilog/cec_regs.svh
// constants of the execution core: widths, fixed addresses, reset values
// and instruction field positions. assumes cec_pkg for the types.
`ifndef CEC_REGS_SVH
`define CEC_REGS_SVH
`define CEC_DW       16
`define CEC_IW       24
`define CEC_PCW      23
`define CEC_NWREG    16
`define CEC_SP_IDX   4'hF
`define CEC_SP_RST   16'h0800
`define CEC_RST_PC   23'h00_0000
`define CEC_VEC_BASE 23'h00_0004
`define CEC_NTRAP    8
`define CEC_NIRQ     118
`define CEC_MMR_TOP  16'h0020
`define CEC_PAGE_ADR 16'h0020
`define CEC_STAT_ADR 16'h0022
`define CEC_DIV_CYC  19
`define CEC_F_LIT    13:0
`define CEC_F_LONG   17:0
`endif

// >>> verilog/cec_pkg.sv
// types of the execution core: opcodes, instruction layout, sequencer
// states, data-space addresses and divider state.
package cec_pkg;
   typedef enum logic [5:0] {
      OP_NOP  = 6'h00, OP_ADD  = 6'h01, OP_SUB  = 6'h02, OP_AND  = 6'h03,
      OP_IOR  = 6'h04, OP_XOR  = 6'h05, OP_MOV  = 6'h06, OP_MOVL = 6'h07,
      OP_MOVF = 6'h08, OP_MUL  = 6'h09, OP_DIV  = 6'h0A, OP_BRA  = 6'h0B,
      OP_GOTO = 6'h0C, OP_CALL = 6'h0D, OP_RET  = 6'h0E, OP_RETI = 6'h0F,
      OP_RPT  = 6'h10, OP_MOVD = 6'h11, OP_TBL  = 6'h12
   } cec_op_t;
   typedef struct packed {
      cec_op_t    op;
      logic [3:0] wd;
      logic [3:0] ws;
      logic [3:0] wb;
      logic [1:0] bm;
      logic [1:0] dm;
      logic [1:0] fl;
   } cec_instr_t;
   typedef enum logic [1:0] {CS_RUN, CS_PUSH2, CS_POP2, CS_SECOND} cec_state_t;
   typedef enum logic [1:0] {RG_LIN, RG_ERAM, RG_PPORT, RG_PMEM} cec_region_t;
   typedef struct packed {
      cec_region_t region;
      logic [7:0]  page;
      logic [14:0] offs;
   } cec_daddr_t;
   typedef struct packed {
      logic [17:0] rem;
      logic [15:0] quo;
      logic [15:0] dvs;
      logic        negq;
      logic        negr;
   } cec_div_t;
endpackage

// >>> verilog/cec_core.sv
// execution core: fetch with one-word prefetch, register file, alu,
// multiplier, divide assist, repeat loop, stack and vectored exceptions.
// assumes program and data memories answer reads in the same cycle.
`timescale 1ns/1ps
`include "cec_regs.svh"

// Behaviour
// - datapath is 16 bits wide; instruction words are 24 bits
// - program counter has 23 bits, reaching eight million words
// - next instruction is fetched while the current one executes
// - one cycle per instruction, except flow change, double move, table, divide
// - repeat instruction re-runs the next one, interruptible anywhere
// - sixteen 16-bit working registers usable as data, address, offset
// - last working register is the stack pointer for calls and exceptions
// - lower 32 Kbytes of data space addressed linearly
// - upper 32 Kbytes form a window onto ram, parallel port or program
// - inherent, relative, literal, direct, plus register indirect modes
// - one data read, register read, data write and fetch per cycle
// - multiplier operates on 17-bit by 17-bit operands
// - signed, unsigned, mixed; 16x16 or 8x8 multiplication
// - every multiply finishes in one cycle
// - non-restoring divide, 32 or 16 by 16 bits, signed or unsigned
// - division takes 19 cycles and may be interrupted between any
// - vectored exceptions: 8 traps and 118 interrupt sources
// - each interrupt carries one of seven priority levels
// - programmer's model registers are reachable as data addresses
module cec_core (
   input  wire logic                clk_sys_i,
   input  wire logic                rst_n_i,
   output logic [`CEC_PCW-1:0]      pm_addr_o,
   input  wire logic [`CEC_IW-1:0]  pm_data_i,
   output logic                     dm_rd_o,
   output cec_pkg::cec_daddr_t      dm_rd_addr_o,
   input  wire logic [`CEC_DW-1:0]  dm_rd_data_i,
   output logic                     dm_wr_o,
   output cec_pkg::cec_daddr_t      dm_wr_addr_o,
   output logic [`CEC_DW-1:0]       dm_wr_data_o,
   input  wire logic [`CEC_NTRAP-1:0] trap_i,
   output logic [`CEC_NTRAP-1:0]    trap_ack_o,
   input  wire logic [2:0]          irq_pri_i,
   input  wire logic [6:0]          irq_vec_i,
   output logic                     irq_ack_o,
   output logic [2:0]               ipl_o,
   output logic                     rpt_active_o
);

   //------------------------------------------------------------
   // state
   //------------------------------------------------------------
   logic [`CEC_DW-1:0]     wreg_ff [`CEC_NWREG];
   logic [`CEC_DW-1:0]     nxt_wreg [`CEC_NWREG];
   logic [`CEC_PCW-1:0]    pc_ff, nxt_pc, irpc_ff, nxt_irpc, tgt_ff, nxt_tgt;
   cec_pkg::cec_instr_t    ir_ff, nxt_ir;
   logic                   irv_ff, nxt_irv;
   cec_pkg::cec_state_t    st_ff, nxt_st;
   logic [13:0]            rpt_ff, nxt_rpt;
   logic                   rpton_ff, nxt_rpton;
   logic [2:0]             ipl_ff, nxt_ipl;
   logic [9:0]             page_ff, nxt_page;
   logic [15:0]            hi_ff, nxt_hi;
   logic                   dwv_ff, nxt_dwv;
   cec_pkg::cec_daddr_t    dwa_ff, nxt_dwa;
   logic [15:0]            dwd_ff, nxt_dwd;
   cec_pkg::cec_div_t      div_ff, nxt_div;

   //------------------------------------------------------------
   // helpers
   //------------------------------------------------------------
   // indirect address: pre-decrement uses the lowered pointer
   function automatic logic [15:0] ea(input logic [1:0] m, input logic [15:0] w);
      return (m == 2'd3) ? 16'(w - 16'h0002) : w;
   endfunction

   // pointer after access: post-increment or pre-decrement
   function automatic logic [15:0] upd(input logic [1:0] m, input logic [15:0] w);
      case (m)
         2'd2:    return 16'(w + 16'h0002);
         2'd3:    return 16'(w - 16'h0002);
         default: return w;
      endcase
   endfunction

   // upper half goes through the window page
   function automatic cec_pkg::cec_daddr_t to_ext(input logic [15:0] a,
                                                  input logic [9:0]  pg);
      cec_pkg::cec_daddr_t d;
      d.offs   = a[14:0];
      d.page   = a[15] ? pg[7:0] : 8'h00;
      d.region = !a[15] ? cec_pkg::RG_LIN :
                 (pg[9:8] == 2'd2) ? cec_pkg::RG_PMEM :
                 pg[8] ? cec_pkg::RG_PPORT : cec_pkg::RG_ERAM;
      return d;
   endfunction

   function automatic logic is_mmr(input logic [15:0] a);
      return (a < `CEC_MMR_TOP) || (a == `CEC_PAGE_ADR) || (a == `CEC_STAT_ADR);
   endfunction

   // data read with register mapping and write-behind bypass
   function automatic logic [15:0] rd_val(input logic [15:0] a);
      if (a < `CEC_MMR_TOP)
         return wreg_ff[a[4:1]];
      else if (a == `CEC_PAGE_ADR)
         return {6'h00, page_ff};
      else if (a == `CEC_STAT_ADR)
         return {13'h0000, ipl_ff};
      else if (dwv_ff && (to_ext(a, page_ff) == dwa_ff))
         return dwd_ff;
      else
         return dm_rd_data_i;
   endfunction

   // word-wide alu; operands and results are 16 bits
   function automatic logic [15:0] alu(input cec_pkg::cec_op_t op,
                                       input logic [15:0] a, input logic [15:0] b);
      case (op)
         cec_pkg::OP_ADD: return 16'(a + b);
         cec_pkg::OP_SUB: return 16'(a - b);
         cec_pkg::OP_AND: return a & b;
         cec_pkg::OP_IOR: return a | b;
         cec_pkg::OP_XOR: return a ^ b;
         default:         return b;
      endcase
   endfunction

   // 17-bit multiplier operand: sign or zero extend, optional byte mode
   function automatic logic [16:0] mop(input logic [15:0] v, input logic sg,
                                       input logic byt);
      if (byt)
         return {{9{sg & v[7]}}, v[7:0]};
      return {sg & v[15], v};
   endfunction

   //------------------------------------------------------------
   // next state
   //------------------------------------------------------------
   cec_pkg::cec_instr_t ins;
   logic [15:0] opa, bptr, dptr, sp, src, res, rd_adr, wr_adr, wr_dat;
   logic        rd_en, wr_en, adv, jmp, take, dst;
   logic [22:0] jtgt;
   logic [33:0] prod;
   logic [31:0] dvd, mag;
   logic [17:0] rs;
   logic [4:0]  step;
   logic [2:0]  tsel;

   // one combinational pass per cycle covers fetch, execute and write
   always_comb begin
      for (int i = 0; i < `CEC_NWREG; i++)
         nxt_wreg[i] = wreg_ff[i];
      ins = ir_ff;
      opa = wreg_ff[ins.ws];
      bptr = wreg_ff[ins.wb];
      dptr = wreg_ff[ins.wd];
      sp = wreg_ff[`CEC_SP_IDX];
      nxt_pc = pc_ff;   nxt_ir = ir_ff;   nxt_irpc = irpc_ff;
      nxt_irv = irv_ff; nxt_st = st_ff;   nxt_tgt = tgt_ff;
      nxt_rpt = rpt_ff; nxt_rpton = rpton_ff;
      nxt_ipl = ipl_ff; nxt_page = page_ff; nxt_hi = hi_ff;
      nxt_div = div_ff; nxt_dwv = 1'b0; nxt_dwa = dwa_ff; nxt_dwd = dwd_ff;
      rd_adr = ea(ins.bm, bptr); rd_en = 1'b0; src = bptr; res = 16'h0000;
      wr_adr = ea(ins.dm, dptr); wr_dat = 16'h0000; wr_en = 1'b0;
      adv = 1'b0; jmp = 1'b0; jtgt = pc_ff; dst = 1'b0;
      pm_addr_o = pc_ff;
      trap_ack_o = '0; irq_ack_o = 1'b0;
      prod = '0; dvd = '0; mag = '0; rs = '0; step = 5'd0; tsel = 3'd0;
      for (int t = `CEC_NTRAP - 1; t >= 0; t--)
         if (trap_i[t])
            tsel = 3'(t);
      // exceptions are taken only in CS_RUN with a valid word, so also between repeat and divide steps
      take = (st_ff == cec_pkg::CS_RUN) && irv_ff &&
             ((|trap_i) || (irq_pri_i > ipl_ff));
      case (st_ff)
         cec_pkg::CS_RUN: begin
            if (take) begin
               // push return address of the unexecuted word
               wr_en = 1'b1; wr_adr = sp; wr_dat = irpc_ff[15:0];
               nxt_wreg[`CEC_SP_IDX] = 16'(sp + 16'h0002);
               // repeat flag rides on the stack so nesting cannot lose it
               nxt_hi = {ipl_ff, rpton_ff, 5'h00, irpc_ff[22:16]};
               nxt_rpton = 1'b0;
               if (|trap_i) begin
                  trap_ack_o[tsel] = 1'b1;
                  nxt_tgt = 23'(`CEC_VEC_BASE + {tsel, 1'b0});
                  nxt_ipl = 3'd7;
               end else begin
                  irq_ack_o = 1'b1;
                  nxt_tgt = 23'(`CEC_VEC_BASE + {(8'(irq_vec_i) + 8'd8), 1'b0});
                  nxt_ipl = irq_pri_i;
               end
               nxt_irv = 1'b0;
               nxt_st = cec_pkg::CS_PUSH2;
            end else if (!irv_ff) begin
               adv = 1'b1;
            end else begin
               adv = 1'b1;
               // repeat holds the word in place, no refetch
               if (rpton_ff) begin
                  if (rpt_ff == 14'h0000) begin
                     nxt_rpton = 1'b0;
                  end else begin
                     nxt_rpt = 14'(rpt_ff - 14'h0001);
                     adv = 1'b0;
                  end
               end
               case (ins.op)
                  cec_pkg::OP_ADD, cec_pkg::OP_SUB, cec_pkg::OP_AND,
                  cec_pkg::OP_IOR, cec_pkg::OP_XOR, cec_pkg::OP_MOV: begin
                     // three operands in one cycle
                     if (ins.bm != 2'd0) begin
                        rd_en = 1'b1;
                        src = rd_val(rd_adr);
                        nxt_wreg[ins.wb] = upd(ins.bm, bptr);
                     end
                     res = alu(ins.op, opa, src);
                     dst = 1'b1;
                  end
                  cec_pkg::OP_MOVL: begin
                     nxt_wreg[ins.wd] = {{2{ir_ff[13]}}, ir_ff[`CEC_F_LIT]};
                  end
                  cec_pkg::OP_MOVF: begin
                     rd_en = 1'b1;
                     rd_adr = {1'b0, ir_ff[`CEC_F_LIT], 1'b0};
                     nxt_wreg[ins.wd] = rd_val(rd_adr);
                  end
                  cec_pkg::OP_MUL: begin
                     // 17x17 signed product, low word then high
                     prod = 34'($signed(mop(opa, ins.fl[1], ins.dm[0])) *
                                $signed(mop(bptr, ins.fl[0], ins.dm[0])));
                     nxt_wreg[{ins.wd[3:1], 1'b0}] = prod[15:0];
                     if (!ins.dm[0])
                        nxt_wreg[{ins.wd[3:1], 1'b1}] = prod[31:16];
                  end
                  cec_pkg::OP_DIV: begin
                     // self-repeating: 1 set-up, 16 steps, fix, sign
                     step = rpton_ff ? 5'(5'd18 - rpt_ff[4:0]) : 5'd0;
                     case (step)
                        5'd0: begin
                           dvd = ins.fl[1] ? {wreg_ff[4'(ins.ws + 4'd1)], opa} :
                                 {{16{ins.fl[0] & opa[15]}}, opa};
                           nxt_div.negq = ins.fl[0] & (dvd[31] ^ bptr[15]);
                           nxt_div.negr = ins.fl[0] & dvd[31];
                           mag = nxt_div.negr ? 32'(-dvd) : dvd;
                           nxt_div.rem = {2'b00, mag[31:16]};
                           nxt_div.quo = mag[15:0];
                           nxt_div.dvs = (ins.fl[0] & bptr[15]) ? 16'(-bptr) : bptr;
                           nxt_rpton = 1'b1;
                           nxt_rpt = 14'(`CEC_DIV_CYC - 2);
                           adv = 1'b0;
                        end
                        5'd17: begin
                           if (div_ff.rem[17])
                              nxt_div.rem = 18'(div_ff.rem + {2'b00, div_ff.dvs});
                        end
                        5'd18: begin
                           nxt_wreg[0] = div_ff.negq ? 16'(-div_ff.quo) : div_ff.quo;
                           nxt_wreg[1] = div_ff.negr ? 16'(-div_ff.rem[15:0]) :
                                         div_ff.rem[15:0];
                        end
                        default: begin
                           // non-restoring step
                           rs = {div_ff.rem[16:0], div_ff.quo[15]};
                           nxt_div.rem = div_ff.rem[17] ?
                                         18'(rs + {2'b00, div_ff.dvs}) :
                                         18'(rs - {2'b00, div_ff.dvs});
                           nxt_div.quo = {div_ff.quo[14:0], ~nxt_div.rem[17]};
                        end
                     endcase
                  end
                  cec_pkg::OP_RPT: begin
                     nxt_rpt = ir_ff[`CEC_F_LIT];
                     nxt_rpton = 1'b1;
                  end
                  cec_pkg::OP_BRA: begin
                     jmp = 1'b1;
                     jtgt = 23'(pc_ff + {{9{ir_ff[13]}}, ir_ff[`CEC_F_LIT]});
                  end
                  cec_pkg::OP_GOTO: begin
                     jmp = 1'b1;
                     jtgt = {5'h00, ir_ff[`CEC_F_LONG]};
                  end
                  cec_pkg::OP_CALL: begin
                     wr_en = 1'b1; wr_adr = sp; wr_dat = pc_ff[15:0];
                     nxt_wreg[`CEC_SP_IDX] = 16'(sp + 16'h0002);
                     nxt_hi = {ipl_ff, 6'h00, pc_ff[22:16]};
                     nxt_tgt = {5'h00, ir_ff[`CEC_F_LONG]};
                     adv = 1'b0; nxt_irv = 1'b0;
                     nxt_st = cec_pkg::CS_PUSH2;
                  end
                  cec_pkg::OP_RET, cec_pkg::OP_RETI: begin
                     rd_en = 1'b1; rd_adr = 16'(sp - 16'h0002);
                     nxt_hi = rd_val(rd_adr);
                     nxt_wreg[`CEC_SP_IDX] = rd_adr;
                     if (ins.op == cec_pkg::OP_RETI) begin
                        nxt_ipl = nxt_hi[15:13];
                        nxt_rpton = nxt_hi[12];
                     end
                     adv = 1'b0; nxt_irv = 1'b0;
                     nxt_st = cec_pkg::CS_POP2;
                  end
                  cec_pkg::OP_MOVD: begin
                     // double move: first word now, second next cycle
                     rd_en = 1'b1; rd_adr = opa;
                     nxt_wreg[{ins.wd[3:1], 1'b0}] = rd_val(rd_adr);
                     adv = 1'b0;
                     nxt_st = cec_pkg::CS_SECOND;
                  end
                  cec_pkg::OP_TBL: begin
                     // program bus borrowed for data, fetch waits
                     pm_addr_o = {bptr[6:0], opa};
                     nxt_wreg[ins.wd] = ins.fl[0] ? {8'h00, pm_data_i[23:16]} :
                                        pm_data_i[15:0];
                     adv = 1'b0;
                     nxt_st = cec_pkg::CS_SECOND;
                  end
                  default: ;
               endcase
            end
         end
         cec_pkg::CS_PUSH2: begin
            wr_en = 1'b1; wr_adr = sp; wr_dat = hi_ff;
            nxt_wreg[`CEC_SP_IDX] = 16'(sp + 16'h0002);
            jmp = 1'b1; jtgt = tgt_ff;
            nxt_st = cec_pkg::CS_RUN;
         end
         cec_pkg::CS_POP2: begin
            rd_en = 1'b1; rd_adr = 16'(sp - 16'h0002);
            nxt_wreg[`CEC_SP_IDX] = rd_adr;
            jmp = 1'b1; jtgt = {hi_ff[6:0], rd_val(rd_adr)};
            nxt_st = cec_pkg::CS_RUN;
         end
         cec_pkg::CS_SECOND: begin
            if (ins.op == cec_pkg::OP_MOVD) begin
               rd_en = 1'b1; rd_adr = 16'(opa + 16'h0002);
               nxt_wreg[{ins.wd[3:1], 1'b1}] = rd_val(rd_adr);
            end
            adv = 1'b1;
            nxt_st = cec_pkg::CS_RUN;
         end
         default: nxt_st = cec_pkg::CS_RUN;
      endcase
      // destination: register direct or memory through a pointer
      if (dst) begin
         if (ins.dm == 2'd0) begin
            nxt_wreg[ins.wd] = res;
         end else begin
            wr_en = 1'b1; wr_dat = res;
            nxt_wreg[ins.wd] = upd(ins.dm, dptr);
         end
      end
      // the one data write per cycle; model registers absorb their own
      if (wr_en) begin
         if (wr_adr < `CEC_MMR_TOP)
            nxt_wreg[wr_adr[4:1]] = wr_dat;
         else if (wr_adr == `CEC_PAGE_ADR)
            nxt_page = wr_dat[9:0];
         else if (wr_adr == `CEC_STAT_ADR)
            nxt_ipl = wr_dat[2:0];
         else begin
            nxt_dwv = 1'b1;
            nxt_dwa = to_ext(wr_adr, page_ff);
            nxt_dwd = wr_dat;
         end
      end
      // prefetched word either moves up or is dropped on a jump
      if (jmp) begin
         nxt_pc = jtgt;
         nxt_irv = 1'b0;
      end else if (adv) begin
         nxt_ir = pm_data_i;
         nxt_irpc = pc_ff;
         nxt_pc = 23'(pc_ff + 23'h00_0001);
         nxt_irv = 1'b1;
      end
   end

   // read strobe only for addresses that leave the core
   assign dm_rd_o      = rd_en && !is_mmr(rd_adr);
   assign dm_rd_addr_o = to_ext(rd_adr, page_ff);
   assign dm_wr_o      = dwv_ff;
   assign dm_wr_addr_o = dwa_ff;
   assign dm_wr_data_o = dwd_ff;
   assign ipl_o        = ipl_ff;
   assign rpt_active_o = rpton_ff;

   //------------------------------------------------------------
   // registers
   //------------------------------------------------------------
   // writes leave one cycle late; the bypass above hides the gap
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < `CEC_NWREG; i++)
            wreg_ff[i] <= '0;
         wreg_ff[`CEC_SP_IDX] <= `CEC_SP_RST;
         pc_ff <= `CEC_RST_PC;  irpc_ff <= '0;  tgt_ff <= '0;
         ir_ff <= '0;           irv_ff <= 1'b0;
         st_ff <= cec_pkg::CS_RUN;
         rpt_ff <= '0; rpton_ff <= 1'b0;
         ipl_ff <= '0; page_ff <= '0; hi_ff <= '0;
         dwv_ff <= 1'b0; dwa_ff <= '0; dwd_ff <= '0; div_ff <= '0;
      end else begin
         for (int i = 0; i < `CEC_NWREG; i++)
            wreg_ff[i] <= nxt_wreg[i];
         pc_ff <= nxt_pc;  irpc_ff <= nxt_irpc;  tgt_ff <= nxt_tgt;
         ir_ff <= nxt_ir;  irv_ff <= nxt_irv;   st_ff <= nxt_st;
         rpt_ff <= nxt_rpt; rpton_ff <= nxt_rpton;
         ipl_ff <= nxt_ipl; page_ff <= nxt_page; hi_ff <= nxt_hi;
         dwv_ff <= nxt_dwv; dwa_ff <= nxt_dwa; dwd_ff <= nxt_dwd;
         div_ff <= nxt_div;
      end
   end

endmodule // cec_core

// >>> verification/cec_core_properties.sv
// port checker of the execution core
// assumes cec_pkg and cec_regs.svh are compiled first
`timescale 1ns/1ps
`include "cec_regs.svh"
module cec_core_properties (
   input wire logic                  clk_sys_i,
   input wire logic                  rst_n_i,
   input wire logic [`CEC_PCW-1:0]   pm_addr_o,
   input wire logic                  dm_rd_o,
   input wire cec_pkg::cec_daddr_t   dm_rd_addr_o,
   input wire logic                  dm_wr_o,
   input wire cec_pkg::cec_daddr_t   dm_wr_addr_o,
   input wire logic [`CEC_NTRAP-1:0] trap_i,
   input wire logic [`CEC_NTRAP-1:0] trap_ack_o,
   input wire logic [2:0]            irq_pri_i,
   input wire logic [6:0]            irq_vec_i,
   input wire logic                  irq_ack_o,
   input wire logic [2:0]            ipl_o,
   input wire logic                  rpt_active_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   chk_reset_state: assert property ($rose(rst_n_i) |-> pm_addr_o == '0 && ipl_o == 3'h0)
      else $error("pc or level not cleared");
   chk_trap_lowest: assert property (|trap_ack_o |-> trap_ack_o == (trap_i & (~trap_i + 8'h01)))
      else $error("trap ack not lowest request");
   chk_trap_level: assert property (|trap_ack_o |-> ##[1:3] ipl_o == 3'h7)
      else $error("trap did not raise level");
   chk_irq_level: assert property (irq_ack_o |-> irq_pri_i > ipl_o)
      else $error("interrupt taken at or below level");
   chk_irq_vector: assert property (irq_ack_o |-> ##[1:3] pm_addr_o == 23'h00_0014 + {irq_vec_i, 1'b0})
      else $error("interrupt vector not fetched");
   chk_irq_masked: assert property (irq_ack_o |-> trap_ack_o == '0 && irq_pri_i != 3'h0)
      else $error("interrupt taken beside trap");
   chk_rd_hidden: assert property (dm_rd_o && dm_rd_addr_o.region == cec_pkg::RG_LIN |-> dm_rd_addr_o.offs >= 15'h0024)
      else $error("model register read left core");
   chk_wr_hidden: assert property (dm_wr_o && dm_wr_addr_o.region == cec_pkg::RG_LIN |-> dm_wr_addr_o.offs >= 15'h0024)
      else $error("model register write left core");
   chk_rpt_paused: assert property ((irq_ack_o || |trap_ack_o) |=> !rpt_active_o)
      else $error("repeat not paused by exception");
endmodule // cec_core_properties
bind cec_core cec_core_properties u_props (.clk_sys_i, .rst_n_i, .pm_addr_o, .dm_rd_o, .dm_rd_addr_o,
   .dm_wr_o, .dm_wr_addr_o, .trap_i, .trap_ack_o, .irq_pri_i, .irq_vec_i, .irq_ack_o, .ipl_o,
   .rpt_active_o);

// >>> verification/cec_mem_model.sv
// program and data memories, both answering in the same cycle
// assumes the bench fills prog before reset is released
`timescale 1ns/1ps
`include "cec_regs.svh"
module cec_mem_model (
   input  wire logic                clk_sys_i,
   input  wire logic [`CEC_PCW-1:0] pm_addr_i,
   output logic [`CEC_IW-1:0]       pm_data_o,
   input  wire logic                dm_rd_i,
   input  wire cec_pkg::cec_daddr_t dm_rd_addr_i,
   output logic [`CEC_DW-1:0]       dm_rd_data_o,
   input  wire logic                dm_wr_i,
   input  wire cec_pkg::cec_daddr_t dm_wr_addr_i,
   input  wire logic [`CEC_DW-1:0]  dm_wr_data_i
);
   logic [`CEC_IW-1:0] prog [4096];
   logic [`CEC_DW-1:0] data [4096];
   logic [`CEC_DW-1:0] last_rd = 16'h0000;
   // idle read bus shows the inverse of the last word, never a stale copy
   assign pm_data_o    = prog[pm_addr_i[11:0]];
   assign dm_rd_data_o = dm_rd_i ? data[dm_rd_addr_i.offs[12:1]] : ~last_rd;
   // one read and one write served per cycle
   always @(posedge clk_sys_i) begin
      if (dm_rd_i) last_rd <= data[dm_rd_addr_i.offs[12:1]];
      if (dm_wr_i) data[dm_wr_addr_i.offs[12:1]] <= dm_wr_data_i;
   end
endmodule // cec_mem_model

// >>> verification/cec_core_tb_top.sv
// bench: random alu, multiply and divide programs under random traps and interrupts
// assumes the core, its checker and the memory model
`timescale 1ns/1ps
`include "cec_regs.svh"
module cec_core_tb_top;
   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [`CEC_PCW-1:0] pm_addr;
   logic [`CEC_IW-1:0] pm_data;
   logic dm_rd, dm_wr, irq_ack;
   cec_pkg::cec_daddr_t dm_rd_addr, dm_wr_addr;
   logic [15:0] dm_rd_data, dm_wr_data, exp_q[$];
   logic [7:0] trap_req = 8'h00, trap_ack;
   logic [2:0] irq_pri = 3'h0, ipl;
   logic [6:0] irq_vec = 7'h00;
   int seed = 32'h40b27f7b, miscompares = 0, total_checks = 0, quiet = 0, rnd;
   cec_core DUT (.clk_sys_i, .rst_n_i, .pm_addr_o(pm_addr), .pm_data_i(pm_data), .dm_rd_o(dm_rd),
      .dm_rd_addr_o(dm_rd_addr), .dm_rd_data_i(dm_rd_data), .dm_wr_o(dm_wr), .dm_wr_addr_o(dm_wr_addr),
      .dm_wr_data_o(dm_wr_data), .trap_i(trap_req), .trap_ack_o(trap_ack), .irq_pri_i(irq_pri),
      .irq_vec_i(irq_vec), .irq_ack_o(irq_ack), .ipl_o(ipl), .rpt_active_o());
   cec_mem_model mem (.clk_sys_i, .pm_addr_i(pm_addr), .pm_data_o(pm_data), .dm_rd_i(dm_rd),
      .dm_rd_addr_i(dm_rd_addr), .dm_rd_data_o(dm_rd_data), .dm_wr_i(dm_wr),
      .dm_wr_addr_i(dm_wr_addr), .dm_wr_data_i(dm_wr_data));
   initial forever #50 clk_sys_i = ~clk_sys_i;
   task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks=%0d mismatches=%0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   function automatic logic [23:0] enc(cec_pkg::cec_op_t op, int wd, int ws, int wb, int dm, int fl);
      return {op, wd[3:0], ws[3:0], wb[3:0], 2'b00, dm[1:0], fl[1:0]};
   endfunction
   // random requests; a quiet gap after each interrupt ack keeps the vector steady
   always @(posedge clk_sys_i) begin
      rnd = $random(seed);
      quiet <= irq_ack ? 8 : (quiet > 0 ? quiet - 1 : 0);
      if (irq_ack) irq_pri <= 3'h0;
      else if (quiet == 0 && irq_pri == 3'h0 && rnd[3:0] == 4'h0) begin
         irq_pri <= (rnd[6:4] == 3'h0) ? 3'h7 : rnd[6:4];
         irq_vec <= 7'(rnd[14:8] % 118);
      end
      if (|trap_ack) trap_req <= trap_req & ~trap_ack;
      else if (rnd[31:26] == 6'h00) trap_req <= rnd[23:16];
   end
   // results stored at 0x100 are compared in order; stack traffic is skipped
   always @(posedge clk_sys_i) begin
      if (rst_n_i && dm_wr && dm_wr_addr.offs == 15'h0100)
         check_word(dm_wr_data, exp_q.size() ? exp_q.pop_front() : 16'hxxxx);
   end
   initial begin
      int pc;
      logic [15:0] a, b;
      logic [31:0] p;
      int x, y;
      foreach (mem.prog[i]) mem.prog[i] = '0;
      mem.prog[0] = {cec_pkg::OP_GOTO, 18'h0_0200};
      for (int v = 4; v < 256; v += 2) mem.prog[v] = {cec_pkg::OP_GOTO, 18'h0_0180};
      mem.prog[12'h180] = {cec_pkg::OP_RETI, 18'h0_0000};
      pc = 32'h0000_0200;
      mem.prog[pc++] = {cec_pkg::OP_MOVL, 4'h4, 14'h0100};
      for (int i = 0; i < 15; i++) begin
         // literals load sign-extended; an odd divisor is never zero
         a = 16'($signed(14'($random(seed))));
         b = 16'($signed(14'($random(seed) | 1)));
         x = (i % 4 > 1) ? int'($signed(a)) : int'(a);
         y = (i % 2) ? int'($signed(b)) : int'(b);
         p = 32'(x * y);
         mem.prog[pc++] = {cec_pkg::OP_MOVL, 4'h1, a[13:0]};
         mem.prog[pc++] = {cec_pkg::OP_MOVL, 4'h2, b[13:0]};
         mem.prog[pc++] = enc(cec_pkg::cec_op_t'(i % 5 + 1), 4, 1, 2, 1, 0);
         mem.prog[pc++] = enc(cec_pkg::OP_MUL, 6, 1, 2, 0, i % 4);
         mem.prog[pc++] = enc(cec_pkg::OP_MOV, 4, 6, 6, 1, 0);
         mem.prog[pc++] = enc(cec_pkg::OP_MOV, 4, 7, 7, 1, 0);
         mem.prog[pc++] = enc(cec_pkg::OP_DIV, 0, 1, 2, 0, 0);
         mem.prog[pc++] = enc(cec_pkg::OP_MOV, 4, 0, 0, 1, 0);
         mem.prog[pc++] = enc(cec_pkg::OP_MOV, 4, 1, 1, 1, 0);
         case (i % 5)
            0: exp_q.push_back(16'(a) + 16'(b));
            1: exp_q.push_back(16'(a) - 16'(b));
            2: exp_q.push_back(16'(a & b));
            3: exp_q.push_back(16'(a | b));
            default: exp_q.push_back(16'(a ^ b));
         endcase
         exp_q.push_back(p[15:0]);
         exp_q.push_back(p[31:16]);
         exp_q.push_back(a / b);
         exp_q.push_back(a % b);
      end
      mem.prog[pc] = {cec_pkg::OP_GOTO, 18'(pc)};
      repeat (3) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      for (int k = 0; k < 5000 && exp_q.size() > 0; k++) @(posedge clk_sys_i);
      check_word(16'(exp_q.size()), 16'h0000);
      tally_and_finish();
   end
endmodule // cec_core_tb_top
